// ==== design/cfgdec_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cfgdec_defines.svh"

module cfgdec_top import cfgdec_pkg::*; #(
  parameter bit FLASH_256K = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Non-volatile configuration words
  input wire logic [31:0] nvm_word0,
  input wire logic [31:0] nvm_word1,
  // Decoded settings
  output logic cfg_ready,
  output cfgdec_dec_s cfg_dec,
  output logic boundary_scan_enable
);

  ////////////////////////////////////////////////////////////////
  // Constants and state

  // Reset image of the whole state
  localparam cfgdec_state_s S_RST = '{
    phase: PH_CAPTURE,
    word0: `CFGDEC_WORD_RST,
    word1: `CFGDEC_WORD_RST,
    scan_rt: 1'b0,
    wdt_sw: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    dec: '0
  };

  cfgdec_state_s s_reg; // Registered state
  cfgdec_state_s s_next; // Next state
  cfgdec_sel_e sel; // Decoded register select
  logic xfer_done; // Access completes this edge

  ////////////////////////////////////////////////////////////////
  // Functions

  // Address decode
  function automatic cfgdec_sel_e reg_sel(input logic [7:0] a);
    cfgdec_sel_e r;
    if (a == `CFGDEC_OFF_WORD0) begin
      r = SEL_WORD0;
    end else if (a == `CFGDEC_OFF_WORD1) begin
      r = SEL_WORD1;
    end else if (a == `CFGDEC_OFF_SCC) begin
      r = SEL_SCC;
    end else if (a == `CFGDEC_OFF_WDT) begin
      r = SEL_WDT;
    end else if (a == `CFGDEC_OFF_STAT) begin
      r = SEL_STAT;
    end else begin
      r = SEL_NONE;
    end
    return r;
  endfunction

  // Effective write-protect code
  function automatic logic [8:0] wp_code(input logic [31:0] w0);
    logic [8:0] c;
    c = w0[`CFGDEC_WP_LSB +: 9];
    if (!FLASH_256K) begin
      c[8:7] = `CFGDEC_WP_TOP2;
    end
    return c;
  endfunction

  // Field decode of both words
  function automatic cfgdec_dec_s decode(
    input logic [31:0] w0,
    input logic [31:0] w1,
    input logic sw
  );
    cfgdec_dec_s d;
    logic [8:0] wp;
    logic [1:0] dbg;
    logic [4:0] ps;
    logic [1:0] ck;
    d = '0;
    wp = wp_code(w0);
    d.wp_all = (wp == `CFGDEC_WP_ALL);
    d.wp_limit = {~wp, 10'h000};
    d.code_protect_on = ~w0[`CFGDEC_CPROT_BIT];
    dbg = d.code_protect_on ? 2'h3 : w0[`CFGDEC_DBG_LSB +: 2];
    d.debugger_en = ~dbg[1];
    d.debug_pair = ~w0[`CFGDEC_SEL_LSB +: 2];
    d.scan_cfg = w0[`CFGDEC_SCAN_BIT];
    case (w1[`CFGDEC_WIN_LSB +: 2])
      2'h3: d.wdt_window_eighths = `CFGDEC_WIN_25;
      2'h2: d.wdt_window_eighths = `CFGDEC_WIN_375;
      2'h1: d.wdt_window_eighths = `CFGDEC_WIN_50;
      default: d.wdt_window_eighths = `CFGDEC_WIN_75;
    endcase
    d.wdt_cfg_on = w1[`CFGDEC_WDTEN_BIT];
    d.wdt_run = d.wdt_cfg_on | sw;
    d.wdt_window_mode = ~w1[`CFGDEC_WATCHDOG_WINDOW_DISABLE_BIT];
    ps = w1[`CFGDEC_PS_LSB +: 5];
    d.wdt_ps_exp = (ps > `CFGDEC_PS_MAX) ? `CFGDEC_PS_MAX : ps;
    ck = w1[`CFGDEC_CKSM_LSB +: 2];
    d.clk_switch_en = ~ck[1];
    d.fail_safe_en = (ck == 2'h0);
    d.pb_div_log2 = w1[`CFGDEC_PBDIV_LSB +: 2];
    d.posc_mode = cfgdec_posc_e'(w1[`CFGDEC_POSC_LSB +: 2]);
    // output needs mode 11 or 00
    d.clkout_en = ~w1[`CFGDEC_CLOCK_OUTPUT_SIGNAL_BIT]
      & ((d.posc_mode == POSC_DISABLED)
      | (d.posc_mode == POSC_EXTERNAL_CLOCK_INPUT));
    d.two_speed_startup = w1[`CFGDEC_TWOSPD_BIT];
    d.secondary_osc_en = w1[`CFGDEC_SOSC_BIT];
    d.init_osc = cfgdec_osc_e'(w1[`CFGDEC_OSC_LSB +: 3]);
    return d;
  endfunction

  // Read mux
  function automatic logic [31:0] read_word(
    input cfgdec_sel_e r,
    input cfgdec_state_s st
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (r)
      SEL_WORD0: v = st.word0;
      SEL_WORD1: v = st.word1;
      SEL_SCC: v[`CFGDEC_SCC_SCAN_BIT] = st.scan_rt;
      SEL_WDT: v[`CFGDEC_WDT_SW_BIT] = st.wdt_sw;
      SEL_STAT: v[3:0] = {st.phase == PH_LOADED,
        st.dec.clkout_en, st.dec.debugger_en, st.dec.wdt_run};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Bus handshake

  // Register select from address
  assign sel = reg_sel(paddr);
  // One wait state, then ready
  assign pready = s_reg.ack;
  // Edge at which the access takes effect
  assign xfer_done = psel & penable & s_reg.ack;
  // Unmapped or write to read-only word
  assign pslverr = s_reg.ack & ((sel == SEL_NONE)
    | (pwrite & ((sel == SEL_WORD0) | (sel == SEL_WORD1)
    | (sel == SEL_STAT))));
  // Read data from flops
  assign prdata = s_reg.rdata;

  ////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    case (s_reg.phase)
      // First edge after reset release
      PH_CAPTURE: begin
        s_next.word0 = nvm_word0;
        s_next.word1 = nvm_word1;
        s_next.scan_rt = nvm_word0[`CFGDEC_SCAN_BIT];
        s_next.phase = PH_LOADED;
      end
      // Words held, bus served
      PH_LOADED: begin
        // Access phase, first cycle
        if (psel && penable && !s_reg.ack) begin
          s_next.ack = 1'b1;
          s_next.rdata = read_word(sel, s_reg);
        end
        // Write takes effect
        if (xfer_done && pwrite && pstrb[0]) begin
          // Runtime scan enable
          if (sel == SEL_SCC) begin
            s_next.scan_rt = pwdata[`CFGDEC_SCC_SCAN_BIT];
          end else if (sel == SEL_WDT && !s_reg.word1[`CFGDEC_WDTEN_BIT]) begin
            s_next.wdt_sw = pwdata[`CFGDEC_WDT_SW_BIT];
          end
        end
      end
      // Unused encodings
      default: begin
        s_next.phase = PH_CAPTURE;
      end
    endcase
    // Decoded settings follow state
    s_next.dec = decode(s_next.word0, s_next.word1, s_next.wdt_sw);
  end

  ////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= S_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  // Core may leave reset once high
  assign cfg_ready = (s_reg.phase == PH_LOADED);
  // Registered decoded settings
  assign cfg_dec = s_reg.dec;
  // Runtime scan enable
  assign boundary_scan_enable = s_reg.scan_rt;

  ////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Boundary at 256K
  property p_wp_256k;
    (cfg_ready && wp_code(s_reg.word0) == `CFGDEC_WP_256K)
      |-> (cfg_dec.wp_limit == `CFGDEC_LIMIT_256K && !cfg_dec.wp_all);
  endproperty
  a_wp_256k: assert property (p_wp_256k)
    else $error("write-protect limit wrong for 256K code");

  // All pages protected
  property p_wp_all;
    (cfg_ready && wp_code(s_reg.word0) == `CFGDEC_WP_ALL) |-> cfg_dec.wp_all;
  endproperty
  a_wp_all: assert property (p_wp_all)
    else $error("all-zero code not protecting all");

  // Pin pair follows code
  property p_pair;
    cfg_ready |-> (cfg_dec.debug_pair == ~s_reg.word0[`CFGDEC_SEL_LSB +: 2]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("debug pin pair mismatch");

  // Runtime scan bit loaded at capture
  property p_scan_load;
    $rose(cfg_ready) |->
      (boundary_scan_enable == s_reg.word0[`CFGDEC_SCAN_BIT]
      && cfg_dec.scan_cfg == boundary_scan_enable);
  endproperty
  a_scan_load: assert property (p_scan_load)
    else $error("runtime scan bit not loaded");

  // Protection forces debugger off
  property p_dbg_forced;
    (cfg_ready && !s_reg.word0[`CFGDEC_CPROT_BIT])
      |-> (cfg_dec.code_protect_on && !cfg_dec.debugger_en);
  endproperty
  a_dbg_forced: assert property (p_dbg_forced)
    else $error("debugger enabled under code protection");

  // Window 75 percent
  property p_win75;
    (cfg_ready && s_reg.word1[`CFGDEC_WIN_LSB +: 2] == 2'h0)
      |-> (cfg_dec.wdt_window_eighths == `CFGDEC_WIN_75);
  endproperty
  a_win75: assert property (p_win75)
    else $error("window size code 00 wrong");

  // Locked watchdog survives a disable write
  property p_wdt_lock;
    (xfer_done && pwrite && sel == SEL_WDT
      && s_reg.word1[`CFGDEC_WDTEN_BIT])
      |=> cfg_dec.wdt_run [*3];
  endproperty
  a_wdt_lock: assert property (p_wdt_lock)
    else $error("locked watchdog was stopped");

  // Postscale clamp
  property p_ps_clamp;
    (cfg_ready && s_reg.word1[`CFGDEC_PS_LSB +: 5] > `CFGDEC_PS_MAX)
      |-> (cfg_dec.wdt_ps_exp == `CFGDEC_PS_MAX);
  endproperty
  a_ps_clamp: assert property (p_ps_clamp)
    else $error("postscale not clamped");

  // Clock output needs mode 11 or 00
  property p_clkout;
    cfg_dec.clkout_en |-> (!s_reg.word1[`CFGDEC_CLOCK_OUTPUT_SIGNAL_BIT]
      && s_reg.word1[`CFGDEC_POSC_LSB +: 2] inside {2'h0, 2'h3});
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock output active in crystal mode");

  // Words never change once held
  property p_hold;
    (cfg_ready && $past(cfg_ready))
      |-> ($stable(s_reg.word0) && $stable(s_reg.word1));
  endproperty
  a_hold: assert property (p_hold)
    else $error("configuration words changed after capture");

  // Ready one edge after release; sampled reset skips the release edge itself
  property p_ready;
    (presetn && !cfg_ready) |=> cfg_ready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("settings not ready after capture edge");

endmodule
`default_nettype wire

// ==== pkg/cfgdec_defines.svh ====
`ifndef CFGDEC_DEFINES_SVH
`define CFGDEC_DEFINES_SVH
// Register byte offsets
`define CFGDEC_OFF_WORD0 8'h00
`define CFGDEC_OFF_WORD1 8'h04
`define CFGDEC_OFF_SCC 8'h08
`define CFGDEC_OFF_WDT 8'h0c
`define CFGDEC_OFF_STAT 8'h10
// Reset value of captured words
`define CFGDEC_WORD_RST 32'hffff_ffff
// Word zero field positions
`define CFGDEC_CPROT_BIT 28
`define CFGDEC_WP_LSB 10
`define CFGDEC_SEL_LSB 3
`define CFGDEC_SCAN_BIT 2
`define CFGDEC_DBG_LSB 0
// Word one field positions
`define CFGDEC_WIN_LSB 24
`define CFGDEC_WDTEN_BIT 23
`define CFGDEC_WATCHDOG_WINDOW_DISABLE_BIT 22
`define CFGDEC_PS_LSB 16
`define CFGDEC_CKSM_LSB 14
`define CFGDEC_PBDIV_LSB 12
`define CFGDEC_CLOCK_OUTPUT_SIGNAL_BIT 10
`define CFGDEC_POSC_LSB 8
`define CFGDEC_TWOSPD_BIT 7
`define CFGDEC_SOSC_BIT 5
`define CFGDEC_OSC_LSB 0
// Control register field positions
`define CFGDEC_SCC_SCAN_BIT 3
`define CFGDEC_WDT_SW_BIT 0
// Write-protect codes and limits
`define CFGDEC_WP_ALL 9'h000
`define CFGDEC_WP_256K 9'h0ff
`define CFGDEC_LIMIT_256K 19'h40000
`define CFGDEC_WP_TOP2 2'h3
// Watchdog postscale ceiling
`define CFGDEC_PS_MAX 5'h14
// Window size in eighths
`define CFGDEC_WIN_25 3'h2
`define CFGDEC_WIN_375 3'h3
`define CFGDEC_WIN_50 3'h4
`define CFGDEC_WIN_75 3'h6
`endif

// ==== pkg/cfgdec_pkg.sv ====
package cfgdec_pkg;
  // Primary oscillator mode field
  typedef enum logic [1:0] {
    POSC_EXTERNAL_CLOCK_INPUT = 2'h0,
    POSC_STANDARD_CRYSTAL = 2'h1,
    POSC_HIGH_SPEED_CRYSTAL = 2'h2,
    POSC_DISABLED = 2'h3
  } cfgdec_posc_e;
  // Initial oscillator select field
  typedef enum logic [2:0] {
    OSC_FAST_INTERNAL_RC = 3'h0,
    OSC_FAST_RC_DIVIDED_PLL = 3'h1,
    OSC_PRIMARY = 3'h2,
    OSC_PRIMARY_PLL = 3'h3,
    OSC_SECONDARY = 3'h4,
    OSC_LOW_POWER_RC = 3'h5,
    OSC_FAST_RC_DIV_SIXTEEN = 3'h6,
    OSC_FAST_RC_DIVIDED = 3'h7
  } cfgdec_osc_e;
  // Loader phase
  typedef enum logic {PH_CAPTURE, PH_LOADED} cfgdec_phase_e;
  // Register select
  typedef enum logic [2:0] {
    SEL_WORD0, SEL_WORD1, SEL_SCC, SEL_WDT, SEL_STAT, SEL_NONE
  } cfgdec_sel_e;
  // Decoded settings for the core
  typedef struct packed {
    logic code_protect_on;
    logic wp_all;
    logic [18:0] wp_limit;
    logic [1:0] debug_pair;
    logic scan_cfg;
    logic debugger_en;
    logic [2:0] wdt_window_eighths;
    logic wdt_cfg_on;
    logic wdt_run;
    logic wdt_window_mode;
    logic [4:0] wdt_ps_exp;
    logic clk_switch_en;
    logic fail_safe_en;
    logic [1:0] pb_div_log2;
    logic clkout_en;
    cfgdec_posc_e posc_mode;
    logic two_speed_startup;
    logic secondary_osc_en;
    cfgdec_osc_e init_osc;
  } cfgdec_dec_s;
  // Whole block state
  typedef struct packed {
    cfgdec_phase_e phase;
    logic [31:0] word0;
    logic [31:0] word1;
    logic scan_rt;
    logic wdt_sw;
    logic ack;
    logic [31:0] rdata;
    cfgdec_dec_s dec;
  } cfgdec_state_s;
endpackage

// ==== sim/cfgdec_prog_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Programmer model: burns the two words with reserved cells filled
module cfgdec_prog_model (
  // Fields the bench asks to program
  input wire logic [31:0] pgm_word0,
  input wire logic [31:0] pgm_word1,
  // Words as held in the non-volatile cells
  output logic [31:0] nvm_word0,
  output logic [31:0] nvm_word1
);
  // Reserved positions of each word
  localparam logic [31:0] RSV0 = 32'h6ef8_03e0;
  localparam logic [31:0] RSV1 = 32'hfc20_0858;
  // Fill reserved cells, never leave primary off when it is the source
  always_comb begin
    nvm_word0 = (pgm_word0 | RSV0) & 32'h7fff_ffff;
    nvm_word1 = pgm_word1 | RSV1;
    if (nvm_word1[2:1] == 2'h1 && nvm_word1[9:8] == 2'h3) begin
      nvm_word1[9:8] = 2'h2;
    end
  end
endmodule
`default_nettype wire

// ==== sim/cfgdec_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module cfgdec_top_test import cfgdec_pkg::*; ;
  // Clock, reset and APB master side
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  // Configuration words and decoded results
  logic [31:0] pgm_word0 = 32'h0;
  logic [31:0] pgm_word1 = 32'h0;
  logic [31:0] nvm_word0;
  logic [31:0] nvm_word1;
  logic cfg_ready;
  cfgdec_dec_s cfg_dec;
  logic boundary_scan_enable;
  // Bookkeeping
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  cfgdec_dec_s e;
  logic [2:0] c;
  logic [4:0] ps;
  logic [8:0] wp_tab [8] = '{9'h0ff, 9'h000, 9'h1ff, 9'h1fe, 9'h17f, 9'h0fe, 9'h1ef, 9'h100};

  ////////////////////////////////////////////////////////////////////
  // Free running 100 MHz clock
  always #5 pclk = ~pclk;

  cfgdec_top i_cfgdec_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .nvm_word0(nvm_word0), .nvm_word1(nvm_word1), .cfg_ready(cfg_ready),
    .cfg_dec(cfg_dec), .boundary_scan_enable(boundary_scan_enable));

  cfgdec_prog_model i_cfgdec_prog_model (.pgm_word0(pgm_word0), .pgm_word1(pgm_word1),
    .nvm_word0(nvm_word0), .nvm_word1(nvm_word1));

  ////////////////////////////////////////////////////////////////////
  // Mismatch report
  task fail(input string msg);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  // Compare one value
  task check(input logic [63:0] got, input logic [63:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail(msg);
    end
  endtask

  // Counts and verdict
  task stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One APB transfer, waits on pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) fail("no pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // Six cycles of reset, then wait for the capture
  task automatic do_reset();
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    check(64'(cfg_ready), 64'h0, "ready in reset");
    check(64'(cfg_dec), 64'h0, "settings in reset");
    check(64'(boundary_scan_enable), 64'h0, "scan in reset");
    presetn <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (cfg_ready === 1'b1) break;
    end
    if (n == 20) fail("no capture");
    @(negedge pclk);
  endtask

  // Expected decode of the two stored words
  function automatic cfgdec_dec_s exp_dec(input logic [31:0] w0, input logic [31:0] w1);
    cfgdec_dec_s x;
    logic [1:0] pm;
    pm = w1[9:8];
    x.code_protect_on = ~w0[28];
    x.wp_all = (w0[18:10] == 9'h000);
    x.wp_limit = {~w0[18:10], 10'h000};
    x.debug_pair = ~w0[4:3];
    x.scan_cfg = w0[2];
    x.debugger_en = w0[28] & ~w0[1];
    x.wdt_window_eighths = w1[25] ? (w1[24] ? 3'h2 : 3'h3) : (w1[24] ? 3'h4 : 3'h6);
    x.wdt_cfg_on = w1[23];
    x.wdt_run = w1[23];
    x.wdt_window_mode = ~w1[22];
    x.wdt_ps_exp = (w1[20:16] > 5'h14) ? 5'h14 : w1[20:16];
    x.clk_switch_en = ~w1[15];
    x.fail_safe_en = ~w1[15] & ~w1[14];
    x.pb_div_log2 = w1[13:12];
    x.clkout_en = ~w1[10] & (pm == 2'h3 || pm == 2'h0);
    x.posc_mode = cfgdec_posc_e'(pm);
    x.two_speed_startup = w1[7];
    x.secondary_osc_en = w1[5];
    x.init_osc = cfgdec_osc_e'(w1[2:0]);
    return x;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Eight configurations, every two-bit field code visited
  initial begin
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      ps = (i < 4) ? 5'(i * 5) : 5'(16 + i);
      @(posedge pclk);
      pgm_word0 <= {3'h0, c[0], 9'h0, wp_tab[i], 5'h0, c[1:0], c[1], c[2:1]};
      pgm_word1 <= {6'h0, c[1:0], c[2], c[0], 1'b0, ps, c[1:0], c[1:0], 1'b0, c[1],
        c[1:0], c[0], 1'b0, ~c[0], 2'h0, c};
      do_reset();
      apb(1'b1, 8'h00, 32'h0);
      check(64'(er), 64'h1, "write to word zero");
      apb(1'b0, 8'h20, 32'h0);
      check(64'({er, rd}), 64'h1_0000_0000, "unmapped read");
      apb(1'b0, 8'h00, 32'h0);
      check(64'(rd), 64'(nvm_word0), "word zero");
      apb(1'b0, 8'h04, 32'h0);
      check(64'(rd), 64'(nvm_word1), "word one");
      e = exp_dec(nvm_word0, nvm_word1);
      check(64'(cfg_dec), 64'(e), "decode");
      check(64'(boundary_scan_enable), 64'(nvm_word0[2]), "runtime scan");
      apb(1'b0, 8'h08, 32'h0);
      check(64'(rd[3]), 64'(nvm_word0[2]), "scan register");
      apb(1'b0, 8'h10, 32'h0);
      check(64'(rd[3:0]), 64'({1'b1, e.clkout_en, e.debugger_en, e.wdt_run}), "status");
      apb(1'b1, 8'h0c, {31'h0, ~nvm_word1[23]});
      apb(1'b1, 8'h08, 32'h0);
      e.wdt_run = 1'b1;
      check(64'(cfg_dec), 64'(e), "watchdog software bit");
      check(64'(boundary_scan_enable), 64'h0, "runtime scan cleared");
      @(posedge pclk);
      pgm_word0 <= ~pgm_word0;
      pgm_word1 <= ~pgm_word1;
      repeat (3) @(posedge pclk);
      check(64'(cfg_dec), 64'(e), "settings held");
      $display("Test case %0d done", i);
    end
    stop_test();
  end

  // Watchdog against a hung handshake
  initial begin
    #100000;
    fail("watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
